/* File: design/phy_mgmt_pkg.sv */
package phy_mgmt_pkg;

    // ****************************************************************
    // register offsets on the management bus
    // ****************************************************************
    localparam logic [4:0] REG_IDENT_HIGH = 5'h02;
    localparam logic [4:0] REG_IDENT_LOW  = 5'h03;
    localparam logic [4:0] REG_ADVERT     = 5'h04;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ADV_NEXT_PAGE_BIT    = 15;
    localparam int ADV_REMOTE_FAULT_BIT = 13;
    localparam int ADV_ASYM_PAUSE_BIT   = 11;
    localparam int ADV_PAUSE_BIT        = 10;
    localparam int ADV_TX100_FULL_BIT   = 8;
    localparam int ID_OUI_LOW_LSB       = 10;
    localparam int ID_MODEL_LSB         = 4;

    // ****************************************************************
    // management frame layout and counts
    // ****************************************************************
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [3:0] HDR_LAST      = 4'hC;
    localparam logic [3:0] TURN_LAST     = 4'h1;
    localparam logic [3:0] DATA_LAST     = 4'hF;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic       START_SECOND  = 1'b1;

    // ****************************************************************
    // speed strap codes
    // ****************************************************************
    localparam logic [1:0] SPEED_ALL      = 2'h0;
    localparam logic [1:0] SPEED_1000_100 = 2'h1;
    localparam logic [1:0] SPEED_1000     = 2'h2;
    localparam logic [1:0] SPEED_1000_10  = 2'h3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic next_page_request;
        logic remote_fault_advert;
        logic asymmetric_pause_advert;
        logic pause_advert;
        logic tx100_full_advert;
    } advert_t;

    typedef struct packed {
        logic [1:0] speed;
        logic       duplex_full;
    } strap_t;

    typedef struct packed {
        logic t1000_full;
        logic t1000_half;
        logic tx100_full;
        logic tx100_half;
        logic t10_full;
        logic t10_half;
    } caps_t;

    localparam advert_t ADVERT_RESET = '0;
    localparam caps_t   CAPS_RESET   = '0;

    typedef enum logic [3:0] {
        ST_PREAMBLE = 4'b0001,
        ST_HEADER   = 4'b0010,
        ST_TURN     = 4'b0100,
        ST_DATA     = 4'b1000
    } mgmt_state_t;

endpackage

/* File: design/strap_capture.sv */
`timescale 1ns/10ps
module strap_capture
    import phy_mgmt_pkg::*;
(
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   resetn_in,
    // strap pins
    input  wire strap_t strap_in,
    // captured abilities
    output caps_t       caps_out,
    output logic        load_out,
    output logic        done_out
);

    // ****************************************************************
    // strap decode
    // ****************************************************************
    function automatic caps_t decode_caps(input strap_t s);
        logic use100;
        logic use10;
        caps_t c;
        use100 = (s.speed == SPEED_ALL) || (s.speed == SPEED_1000_100);
        use10  = (s.speed == SPEED_ALL) || (s.speed == SPEED_1000_10);
        c.t1000_half = 1'b1;
        c.t1000_full = s.duplex_full;
        c.tx100_half = use100;
        c.tx100_full = use100 & s.duplex_full;
        c.t10_half   = use10;
        c.t10_full   = use10 & s.duplex_full;
        return c;
    endfunction

    caps_t caps_ff;
    logic  load_ff;
    logic  done_ff;

    // ****************************************************************
    // capture on the first edge after reset release
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= ~done_ff;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            caps_ff <= CAPS_RESET;
        end else if (!done_ff) begin
            caps_ff <= decode_caps(strap_in);
        end
    end

    assign caps_out = caps_ff;
    assign load_out = load_ff;
    assign done_out = done_ff;

endmodule

/* File: design/phy_ident_and_advert_regs.sv */
`timescale 1ns/10ps
// Functional notes
// - first identifier register returns identifier bits 3 to 18, fixed, read-only.
// - identifier bits 1 and 2 are stored in neither register.
// - both registers together form identifier, model number, then revision.
// - all 32 identifier bits may read as zero instead.
// - second register bits 15 to 10 carry identifier bits 19 to 24.
// - second register bits 9 to 4 carry six-bit model number, msb at 9.
// - second register bits 3 to 0 carry four-bit revision, msb at 3.
// - advertisement bit 15 is read-write next-page request, reset 0.
// - advertisement bit 14 ignores writes and reads 0.
// - advertisement bit 13 is read-write remote fault flag, reset 0.
// - advertisement bit 12 reads 0; controller writes it as 0.
// - advertisement bit 11 is read-write asymmetric pause flag, reset 0.
// - advertisement bit 10 is read-write pause flag, reset 0.
// - advertisement bit 9 is read-only and always 0.
// - advertisement bit 8 read-write, reset value from duplex and speed straps.
// - speed strap decodes to the advertised speed set.
// - duplex abilities follow duplex strap combined with speed decode.
module phy_ident_and_advert_regs
    import phy_mgmt_pkg::*;
#(
    // identity values, arbitrary
    parameter logic [23:0] OUI_CODE    = 24'h123456,
    parameter logic [5:0]  MODEL_CODE  = 6'h05,
    parameter logic [3:0]  REV_CODE    = 4'h1,
    parameter bit          BLANK_IDENT = 1'b0
)
(
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   resetn_in,
    // management serial bus
    input  wire logic   mdc_in,
    input  wire logic   mdio_in,
    output logic        mdio_out,
    output logic        mdio_oe_n_out,
    // straps
    input  wire logic [4:0] phy_addr_in,
    input  wire strap_t strap_in,
    // advertised state
    output advert_t     advert_out,
    output caps_t       caps_out,
    output logic        straps_valid_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    mgmt_state_t state_ff;
    mgmt_state_t nxt_state;
    logic        mdc_q_ff;
    logic        mdc_rise;
    logic [5:0]  ones_ff;
    logic [5:0]  nxt_ones;
    logic        pre_ok_ff;
    logic        nxt_pre_ok;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic [12:0] hdr_ff;
    logic [12:0] nxt_hdr;
    logic        rd_ff;
    logic        nxt_rd;
    logic        wr_ff;
    logic        nxt_wr;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic        mdio_ff;
    logic        nxt_mdio;
    logic        oe_n_ff;
    logic        nxt_oe_n;
    logic        commit;
    logic [4:0]  phy_addr_ff;
    advert_t     advert_ff;
    caps_t       caps_w;
    logic        load_w;
    logic        done_w;

    // ****************************************************************
    // strap capture
    // ****************************************************************
    strap_capture u_strap (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .strap_in  (strap_in),
        .caps_out  (caps_w),
        .load_out  (load_w),
        .done_out  (done_w)
    );

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phy_addr_ff <= 5'h00;
        end else if (!done_w) begin
            phy_addr_ff <= phy_addr_in;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    function automatic logic [15:0] ident_high_word();
        logic [15:0] w;
        w = OUI_CODE[21:6];
        if (BLANK_IDENT) begin
            w = 16'h0000;
        end
        return w;
    endfunction

    function automatic logic [15:0] ident_low_word();
        logic [15:0] w;
        w = 16'h0000;
        w[ID_OUI_LOW_LSB +: 6] = OUI_CODE[5:0];
        w[ID_MODEL_LSB +: 6]   = MODEL_CODE;
        w[3:0]                 = REV_CODE;
        if (BLANK_IDENT) begin
            w = 16'h0000;
        end
        return w;
    endfunction

    function automatic logic [15:0] advert_word(input advert_t a);
        logic [15:0] w;
        w = 16'h0000;
        w[ADV_NEXT_PAGE_BIT]    = a.next_page_request;
        w[ADV_REMOTE_FAULT_BIT] = a.remote_fault_advert;
        w[ADV_ASYM_PAUSE_BIT]   = a.asymmetric_pause_advert;
        w[ADV_PAUSE_BIT]        = a.pause_advert;
        w[ADV_TX100_FULL_BIT]   = a.tx100_full_advert;
        return w;
    endfunction

    function automatic logic [15:0] read_word(input logic [4:0] addr, input advert_t a);
        logic [15:0] w;
        w = 16'h0000;
        if (addr == REG_IDENT_HIGH) begin
            w = ident_high_word();
        end else if (addr == REG_IDENT_LOW) begin
            w = ident_low_word();
        end else if (addr == REG_ADVERT) begin
            w = advert_word(a);
        end
        return w;
    endfunction

    // ****************************************************************
    // management clock edge
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mdc_q_ff <= 1'b0;
        end else begin
            mdc_q_ff <= mdc_in;
        end
    end

    assign mdc_rise = mdc_in & ~mdc_q_ff;

    // ****************************************************************
    // header decode
    // ****************************************************************
    function automatic logic op_is(input logic [12:0] h, input logic [1:0] op);
        return h[11:10] == op;
    endfunction

    function automatic logic addr_hit(input logic [12:0] h, input logic [4:0] a);
        return h[9:5] == a;
    endfunction

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    always_comb begin
        nxt_state  = state_ff;
        nxt_ones   = ones_ff;
        nxt_pre_ok = pre_ok_ff;
        nxt_cnt    = cnt_ff;
        nxt_hdr    = hdr_ff;
        nxt_rd     = rd_ff;
        nxt_wr     = wr_ff;
        nxt_shift  = shift_ff;
        nxt_mdio   = mdio_ff;
        nxt_oe_n   = oe_n_ff;
        commit     = 1'b0;
        if (mdc_rise) begin
            unique case (state_ff)
                ST_PREAMBLE: begin
                    nxt_oe_n = 1'b1;
                    if (mdio_in) begin
                        if (ones_ff != PREAMBLE_ONES) begin
                            nxt_ones = ones_ff + 6'h01;
                        end else begin
                            nxt_pre_ok = 1'b1;
                        end
                    end else begin
                        // start bit after preamble, or after idle once allowed
                        if ((ones_ff == PREAMBLE_ONES) || (pre_ok_ff && (ones_ff != 6'h00))) begin
                            nxt_pre_ok = 1'b1;
                            nxt_state  = ST_HEADER;
                            nxt_cnt    = 4'h0;
                        end
                        nxt_ones = 6'h00;
                    end
                end
                ST_HEADER: begin
                    nxt_hdr = {hdr_ff[11:0], mdio_in};
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == HDR_LAST) begin
                        nxt_cnt = 4'h0;
                        if ((nxt_hdr[12] != START_SECOND) ||
                            (!op_is(nxt_hdr, OP_READ) && !op_is(nxt_hdr, OP_WRITE))) begin
                            // bad start or opcode: full preamble needed again
                            nxt_pre_ok = 1'b0;
                            nxt_state  = ST_PREAMBLE;
                        end else begin
                            nxt_rd    = op_is(nxt_hdr, OP_READ) && addr_hit(nxt_hdr, phy_addr_ff);
                            nxt_wr    = op_is(nxt_hdr, OP_WRITE) && addr_hit(nxt_hdr, phy_addr_ff);
                            nxt_shift = read_word(nxt_hdr[4:0], advert_ff);
                            nxt_state = ST_TURN;
                        end
                    end
                end
                ST_TURN: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == 4'h0) begin
                        if (rd_ff) begin
                            nxt_mdio = 1'b0;
                            nxt_oe_n = 1'b0;
                        end
                    end else if (cnt_ff == TURN_LAST) begin
                        nxt_cnt = 4'h0;
                        if (rd_ff) begin
                            nxt_mdio  = shift_ff[15];
                            nxt_shift = {shift_ff[14:0], 1'b0};
                            nxt_state = ST_DATA;
                        end else if (op_is(nxt_hdr, OP_WRITE) && mdio_in) begin
                            // write turnaround must end low
                            nxt_pre_ok = 1'b0;
                            nxt_state  = ST_PREAMBLE;
                        end else begin
                            nxt_state = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (rd_ff) begin
                        nxt_mdio  = shift_ff[15];
                        nxt_shift = {shift_ff[14:0], 1'b0};
                    end else begin
                        nxt_shift = {shift_ff[14:0], mdio_in};
                    end
                    if (cnt_ff == DATA_LAST) begin
                        nxt_oe_n  = 1'b1;
                        nxt_mdio  = 1'b1;
                        nxt_cnt   = 4'h0;
                        nxt_ones  = 6'h00;
                        commit    = wr_ff;
                        nxt_rd    = 1'b0;
                        nxt_wr    = 1'b0;
                        nxt_state = ST_PREAMBLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // sequencer state
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff  <= ST_PREAMBLE;
            ones_ff   <= 6'h00;
            pre_ok_ff <= 1'b0;
            cnt_ff    <= 4'h0;
        end else begin
            state_ff  <= nxt_state;
            ones_ff   <= nxt_ones;
            pre_ok_ff <= nxt_pre_ok;
            cnt_ff    <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hdr_ff   <= 13'h0000;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            shift_ff <= 16'h0000;
        end else begin
            hdr_ff   <= nxt_hdr;
            rd_ff    <= nxt_rd;
            wr_ff    <= nxt_wr;
            shift_ff <= nxt_shift;
        end
    end

    // ****************************************************************
    // serial data pin
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mdio_ff <= 1'b1;
            oe_n_ff <= 1'b1;
        end else begin
            mdio_ff <= nxt_mdio;
            oe_n_ff <= nxt_oe_n;
        end
    end

    // ****************************************************************
    // advertisement register
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            advert_ff <= ADVERT_RESET;
        end else if (commit && (hdr_ff[4:0] == REG_ADVERT)) begin
            // only the writable bits are kept
            advert_ff.next_page_request       <= nxt_shift[ADV_NEXT_PAGE_BIT];
            advert_ff.remote_fault_advert     <= nxt_shift[ADV_REMOTE_FAULT_BIT];
            advert_ff.asymmetric_pause_advert <= nxt_shift[ADV_ASYM_PAUSE_BIT];
            advert_ff.pause_advert            <= nxt_shift[ADV_PAUSE_BIT];
            advert_ff.tx100_full_advert       <= nxt_shift[ADV_TX100_FULL_BIT];
        end else if (load_w) begin
            advert_ff.tx100_full_advert <= caps_w.tx100_full;
        end
    end
    // identifier offsets have no storage, so writes there fall away

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mdio_out         = mdio_ff;
    assign mdio_oe_n_out    = oe_n_ff;
    assign advert_out       = advert_ff;
    assign caps_out         = caps_w;
    assign straps_valid_out = done_w;

endmodule

/* File: test/phy_regs_monitor.sv */
`timescale 1ns/10ps
module phy_regs_monitor
    import phy_mgmt_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    // pins and state
    input  wire logic       mdc_in,
    input  wire logic       mdio_in,
    input  wire logic       mdio_out,
    input  wire logic       mdio_oe_n_out,
    input  wire logic [4:0] phy_addr_in,
    input  wire strap_t     strap_in,
    input  wire advert_t    advert_out,
    input  wire caps_t      caps_out,
    input  wire logic       straps_valid_out
);
    // ****************************************************************
    // strap decode and properties
    // ****************************************************************
    function automatic caps_t dec(input strap_t s);
        logic a;
        logic b;
        a = !s.speed[1];
        b = (s.speed == 2'h0) || (s.speed == 2'h3);
        return {s.duplex_full, 1'b1, s.duplex_full & a, a, s.duplex_full & b, b};
    endfunction

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    AST_RESET_IDLE: assert property (disable iff (1'b0)
        !resetn_in |-> mdio_oe_n_out && advert_out == '0 && caps_out == '0 && !straps_valid_out)
        else $error("outputs not idle in reset");
    AST_STRAP_VALID: assert property ($rose(resetn_in) |=> straps_valid_out)
        else $error("straps not valid after reset");
    AST_CAPS_DECODE: assert property (
        $rose(straps_valid_out) |-> caps_out == dec($past(strap_in)))
        else $error("speed strap decode wrong");
    AST_CAPS_HOLD: assert property (straps_valid_out |=> $stable(caps_out))
        else $error("abilities changed after capture");
    AST_TX100_LOAD: assert property (
        $rose(straps_valid_out) |=> advert_out == advert_t'({4'h0, caps_out.tx100_full}))
        else $error("advert reset value wrong");
    AST_TA_ZERO: assert property (
        $fell(mdio_oe_n_out) |-> !mdio_out ##1 !mdio_oe_n_out [*8])
        else $error("turnaround drive wrong");
    AST_DRIVE_LEN: assert property ($fell(mdio_oe_n_out) |-> ##[66:70] $rose(mdio_oe_n_out))
        else $error("read drive length wrong");
    AST_DRIVE_ON_MDC: assert property (
        $changed(mdio_out) && !mdio_oe_n_out |-> $past(mdc_in))
        else $error("data changed without clock rise");
    AST_ADVERT_WRITE: assert property (
        $changed(advert_out) && $past(straps_valid_out, 2) |-> $past(mdc_in) && mdio_oe_n_out)
        else $error("advert changed outside a write");
endmodule

bind phy_ident_and_advert_regs phy_regs_monitor mon_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n_out), .phy_addr_in(phy_addr_in), .strap_in(strap_in),
    .advert_out(advert_out), .caps_out(caps_out), .straps_valid_out(straps_valid_out));

/* File: test/mgmt_station.sv */
`timescale 1ns/10ps
module mgmt_station (
    // clock and request
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic        rd_in,
    input  wire logic [5:0]  pre_in,
    input  wire logic [31:0] frame_in,
    // serial bus
    input  wire logic        mdio_in,
    output logic             mdc_out,
    output logic             mdio_out,
    output logic             oe_out,
    // completion
    output logic             done_out,
    output logic [15:0]      rdata_out
);
    // ****************************************************************
    // frame engine, 4 clocks per bit, mdc idle low
    // ****************************************************************
    int i;
    int k;
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        oe_out = 1'b0;
        done_out = 1'b0;
        rdata_out = '0;
    end
    always begin
        @(posedge clk_in);
        done_out <= 1'b0;
        if (go_in) begin
            for (i = 0; i < pre_in + 32; i++) begin
                k = i - pre_in;
                // let go of the line from turnaround on in reads
                oe_out   <= !(rd_in && k >= 14);
                mdio_out <= (k < 0) ? 1'b1 : (frame_in[31 - k] & (k != 19));
                mdc_out  <= 1'b0;
                repeat (2) @(posedge clk_in);
                mdc_out <= 1'b1;
                if (rd_in && k >= 16) begin
                    rdata_out <= {rdata_out[14:0], mdio_in};
                end
                repeat (2) @(posedge clk_in);
            end
            mdc_out <= 1'b0;
            oe_out  <= 1'b0;
            repeat (2) @(posedge clk_in);
            done_out <= 1'b1;
        end
    end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import phy_mgmt_pkg::*;
    // ****************************************************************
    // bench state
    // ****************************************************************
    localparam logic [23:0] OUI_V   = 24'h3CA5E1; // arbitrary
    localparam logic [5:0]  MODEL_V = 6'h2B;      // arbitrary
    localparam logic [3:0]  REV_V   = 4'h6;       // arbitrary
    localparam logic [31:0] ID_V    = {OUI_V[21:0], MODEL_V, REV_V};
    logic        clk_in    = 1'b0;
    logic        resetn_in = 1'b1;
    logic        go        = 1'b0;
    logic        rd        = 1'b0;
    logic [5:0]  pre       = 6'h20;
    logic [31:0] frame     = '0;
    logic [4:0]  addr      = 5'h00;
    strap_t      strap     = '0;
    logic [31:0] lfsr_q    = 32'hD4916126;
    logic        mdc, st_mdio, st_oe, done, dut_mdio, dut_oe_n, svalid, blk_mdio, blk_oe_n;
    logic [15:0] rdata, wd;
    advert_t     advert;
    caps_t       caps, ec;
    int          failures = 0;
    int          checks   = 0;
    int          s, r, n;
    wire         mdio_line = !dut_oe_n ? dut_mdio : (!blk_oe_n ? blk_mdio : (st_oe ? st_mdio : 1'b1));

    always #5 clk_in = ~clk_in;

    phy_ident_and_advert_regs #(.OUI_CODE(OUI_V), .MODEL_CODE(MODEL_V), .REV_CODE(REV_V), .BLANK_IDENT(1'b0))
    dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .mdc_in(mdc), .mdio_in(mdio_line), .mdio_out(dut_mdio),
           .mdio_oe_n_out(dut_oe_n), .phy_addr_in(addr), .strap_in(strap), .advert_out(advert),
           .caps_out(caps), .straps_valid_out(svalid));
    // second device on the same bus, identifier blanked
    phy_ident_and_advert_regs #(.OUI_CODE(OUI_V), .MODEL_CODE(MODEL_V), .REV_CODE(REV_V), .BLANK_IDENT(1'b1))
    blank_u (.clk_in(clk_in), .resetn_in(resetn_in), .mdc_in(mdc), .mdio_in(mdio_line), .mdio_out(blk_mdio),
             .mdio_oe_n_out(blk_oe_n), .phy_addr_in(addr ^ 5'h10), .strap_in(strap), .advert_out(),
             .caps_out(), .straps_valid_out());
    mgmt_station stn_u (.clk_in(clk_in), .go_in(go), .rd_in(rd), .pre_in(pre), .frame_in(frame),
                        .mdio_in(mdio_line), .mdc_out(mdc), .mdio_out(st_mdio), .oe_out(st_oe),
                        .done_out(done), .rdata_out(rdata));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic caps_t exp_caps(input strap_t t);
        logic a;
        logic b;
        a = !t.speed[1];
        b = (t.speed == 2'h0) || (t.speed == 2'h3);
        return {t.duplex_full, 1'b1, t.duplex_full & a, a, t.duplex_full & b, b};
    endfunction
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic mgmt(input logic [1:0] st, input logic [1:0] op, input logic [4:0] ad,
                        input logic [4:0] rg, input logic [15:0] d, input logic [5:0] pl);
        int w;
        frame <= {st, op, ad, rg, 2'b10, d};
        pre   <= pl;
        rd    <= (op == OP_READ);
        go    <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        w = 0;
        while (done !== 1'b1 && w < 3000) begin
            @(posedge clk_in);
            w++;
        end
        if (w == 3000) begin
            failures++;
            $display("CHECK FAILED at %0t: frame timeout", $time);
            end_sim;
        end
    endtask
    task automatic adv(input logic [15:0] e);
        mgmt(2'b01, OP_READ, addr, REG_ADVERT, 16'h0000, 6'h20);
        chk(rdata, e);
        chk(16'(advert), 16'({e[15], e[13], e[11], e[10], e[8]}));
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        for (s = 0; s < 8; s++) begin
            resetn_in <= 1'b0;
            strap     <= strap_t'(3'(s));
            lfsr_q = lfsr(lfsr_q);
            addr      <= lfsr_q[4:0];
            repeat (3) @(posedge clk_in);
            resetn_in <= 1'b1;
            repeat (4) @(posedge clk_in);
            ec = exp_caps(strap);
            chk(16'(caps), 16'(ec));
            adv({7'h00, ec.tx100_full, 8'h00});
            for (r = 2; r < 4; r++) begin
                lfsr_q = lfsr(lfsr_q);
                mgmt(2'b01, OP_WRITE, addr, 5'(r), lfsr_q[15:0], 6'h01);
                mgmt(2'b01, OP_READ, addr, 5'(r), 16'h0000, 6'h01);
                chk(rdata, (r == 2) ? ID_V[31:16] : ID_V[15:0]);
                mgmt(2'b01, OP_READ, addr ^ 5'h10, 5'(r), 16'h0000, 6'h01);
                chk(rdata, 16'h0000);
            end
            mgmt(2'b01, OP_READ, addr, 5'h1F, 16'h0000, 6'h01);
            chk(rdata, 16'h0000);
        end
        for (n = 0; n < 12; n++) begin
            lfsr_q = lfsr(lfsr_q);
            wd = (n == 0) ? 16'hFFFF : lfsr_q[15:0];
            mgmt(2'b01, OP_WRITE, addr, REG_ADVERT, wd, 6'h01);
            adv(wd & 16'hAD00);
        end
        // foreign address, then a broken start that loses the preamble
        mgmt(2'b01, OP_WRITE, addr ^ 5'h01, REG_ADVERT, ~wd, 6'h01);
        adv(wd & 16'hAD00);
        mgmt(2'b00, OP_WRITE, addr, REG_ADVERT, ~wd, 6'h01);
        mgmt(2'b01, OP_WRITE, addr, REG_ADVERT, ~wd, 6'h01);
        adv(wd & 16'hAD00);
        // illegal opcode also loses the preamble
        mgmt(2'b01, 2'b11, addr, REG_ADVERT, ~wd, 6'h01);
        mgmt(2'b01, OP_WRITE, addr, REG_ADVERT, ~wd, 6'h01);
        adv(wd & 16'hAD00);
        end_sim;
    end
endmodule
